/* File: rtccfg_pkg.sv */
package rtccfg_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00_A1;
  localparam logic [7:0] ADDR_FRACTION = 8'h00_A2;
  localparam logic [7:0] ADDR_SECOND = 8'h00_A3;
  localparam logic [7:0] ADDR_MINUTE = 8'h00_A4;
  localparam logic [7:0] ADDR_HOUR = 8'h00_A5;
  localparam logic [7:0] ADDR_TARGET = 8'h00_A6;
  localparam logic [7:0] ADDR_KEY = 8'h00_C1;
  localparam logic [7:0] ADDR_PIN_IRQ = 8'h00_FF;
  localparam logic [7:0] UNLOCK_VALUE = 8'h00_EA;
  localparam int BIT_MIDNIGHT = 7;
  localparam int BIT_DAY_LEN = 6;
  localparam int BIT_BASE_HI = 5;
  localparam int BIT_BASE_LO = 4;
  localparam int BIT_SINGLE = 3;
  localparam int BIT_ALARM = 2;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_KEEP1 = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00_01;
  localparam logic [7:0] ZERO8 = 8'h00_00;
  localparam logic [7:0] FRACTION_LAST = 8'h00_7F;
  localparam logic [7:0] SIXTY_LAST = 8'h00_3B;
  localparam logic [7:0] HOUR_LAST_24 = 8'h00_17;
  localparam logic [7:0] HOUR_LAST_256 = 8'h00_FF;
  localparam int TICK_HZ = 128;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  typedef enum logic [1:0] {
    RTCCFG_BASE_FRACTION = 2'b00,
    RTCCFG_BASE_SECOND = 2'b01,
    RTCCFG_BASE_MINUTE = 2'b10,
    RTCCFG_BASE_HOUR = 2'b11
  } rtccfg_base_t;
endpackage

/* File: rtccfg_wrap_counter.sv */
`timescale 1ns/1ps
module rtccfg_wrap_counter
  import rtccfg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic por_n,
  input wire logic clk_en,
  input wire logic step,
  input wire logic [WIDTH-1:0] last,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  logic [WIDTH-1:0] next_count;

  assign wrap = step && (count == last);
  assign next_count = load ? load_data : wrap ? '0 : step ? count + 1'b1 : count;

  always_ff @(posedge ref_clk) begin
    if (!por_n) begin
      count <= '0;
    end else if (clk_en) begin
      count <= next_count;
    end
  end
endmodule

/* File: rtccfg_top.sv */
`timescale 1ns/1ps
module rtccfg_top
  import rtccfg_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic midnight_wake,
  output logic deep_saving_block,
  output logic rtc_irq,
  output logic [7:0] pin_irq_config
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [7:0] cfg;
  logic [7:0] key;
  logic [7:0] target;
  logic [7:0] ivl_count;
  logic [7:0] frac_c;
  logic [7:0] sec_c;
  logic [7:0] min_c;
  logic [7:0] hour_c;
  logic [31:0] pre_cnt;
  logic wake_pending;
  logic tick;
  logic frac_wrap;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic unlocked;
  logic wr_cfg;
  logic wr_key;
  logic wr_target;
  logic wr_pin;
  logic wr_frac;
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic base_step;
  logic ivl_match;
  logic ivl_run;
  logic [7:0] hour_last;
  logic [7:0] next_cfg;
  logic [7:0] next_ivl;
  logic [7:0] next_rdata;
  logic [31:0] next_pre;
  rtccfg_base_t base_sel;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  assign unlocked = (key == UNLOCK_VALUE);
  assign wr_cfg = sfr_wr && addr_is(sfr_addr, ADDR_CONFIG);
  assign wr_key = sfr_wr && addr_is(sfr_addr, ADDR_KEY);
  assign wr_target = sfr_wr && addr_is(sfr_addr, ADDR_TARGET);
  assign wr_pin = sfr_wr && unlocked && addr_is(sfr_addr, ADDR_PIN_IRQ);
  assign wr_frac = sfr_wr && unlocked && addr_is(sfr_addr, ADDR_FRACTION);
  assign wr_sec = sfr_wr && unlocked && addr_is(sfr_addr, ADDR_SECOND);
  assign wr_min = sfr_wr && unlocked && addr_is(sfr_addr, ADDR_MINUTE);
  assign wr_hour = sfr_wr && unlocked && addr_is(sfr_addr, ADDR_HOUR);

  // ---------------------------------------------------------------
  // 1/128 s prescaler and time counters
  // ---------------------------------------------------------------
  assign tick = (pre_cnt == 32'(TICK_DIV - 1));
  assign next_pre = tick ? '0 : pre_cnt + 32'd1;
  assign hour_last = cfg[BIT_DAY_LEN] ? HOUR_LAST_24 : HOUR_LAST_256;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pre_cnt <= '0;
    end else if (clk_en) begin
      pre_cnt <= next_pre;
    end
  end

  rtccfg_wrap_counter #(.WIDTH(8)) u_frac (
    .ref_clk(ref_clk),
    .por_n(rst_n),
    .clk_en(clk_en),
    .step(tick),
    .last(FRACTION_LAST),
    .load(wr_frac),
    .load_data(sfr_wdata),
    .count(frac_c),
    .wrap(frac_wrap)
  );

  rtccfg_wrap_counter #(.WIDTH(8)) u_sec (
    .ref_clk(ref_clk),
    .por_n(rst_n),
    .clk_en(clk_en),
    .step(frac_wrap),
    .last(SIXTY_LAST),
    .load(wr_sec),
    .load_data(sfr_wdata),
    .count(sec_c),
    .wrap(sec_wrap)
  );

  rtccfg_wrap_counter #(.WIDTH(8)) u_min (
    .ref_clk(ref_clk),
    .por_n(rst_n),
    .clk_en(clk_en),
    .step(sec_wrap),
    .last(SIXTY_LAST),
    .load(wr_min),
    .load_data(sfr_wdata),
    .count(min_c),
    .wrap(min_wrap)
  );

  rtccfg_wrap_counter #(.WIDTH(8)) u_hour (
    .ref_clk(ref_clk),
    .por_n(rst_n),
    .clk_en(clk_en),
    .step(min_wrap),
    .last(hour_last),
    .load(wr_hour),
    .load_data(sfr_wdata),
    .count(hour_c),
    .wrap(hour_wrap)
  );

  // ---------------------------------------------------------------
  // interval timer
  // ---------------------------------------------------------------
  assign base_sel = rtccfg_base_t'(cfg[BIT_BASE_HI:BIT_BASE_LO]);
  assign base_step = (base_sel == RTCCFG_BASE_FRACTION) ? tick :
                     (base_sel == RTCCFG_BASE_SECOND) ? frac_wrap :
                     (base_sel == RTCCFG_BASE_MINUTE) ? sec_wrap : min_wrap;
  assign ivl_run = cfg[BIT_ENABLE] && (ivl_count != target || !cfg[BIT_SINGLE]);
  assign ivl_match = ivl_run && base_step && (ivl_count + 8'd1 == target);
  // single-shot parks at the target; repeating restarts from zero
  assign next_ivl = !cfg[BIT_ENABLE] ? ZERO8 :
                    ivl_match ? (cfg[BIT_SINGLE] ? target : ZERO8) :
                    (ivl_run && base_step) ? ivl_count + 8'd1 : ivl_count;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ivl_count <= ZERO8;
    end else if (clk_en) begin
      ivl_count <= next_ivl;
    end
  end

  // ---------------------------------------------------------------
  // configuration register and flags
  // ---------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    if (wr_cfg) begin
      next_cfg[BIT_DAY_LEN] = sfr_wdata[BIT_DAY_LEN];
      next_cfg[BIT_BASE_HI] = sfr_wdata[BIT_BASE_HI];
      next_cfg[BIT_BASE_LO] = sfr_wdata[BIT_BASE_LO];
      next_cfg[BIT_SINGLE] = sfr_wdata[BIT_SINGLE];
      next_cfg[BIT_ENABLE] = sfr_wdata[BIT_ENABLE];
      next_cfg[BIT_KEEP1] = sfr_wdata[BIT_KEEP1];
      next_cfg[BIT_MIDNIGHT] = cfg[BIT_MIDNIGHT] & sfr_wdata[BIT_MIDNIGHT];
      next_cfg[BIT_ALARM] = cfg[BIT_ALARM] & sfr_wdata[BIT_ALARM];
    end
    // hardware set wins over a clear in the same cycle
    if (hour_wrap) begin
      next_cfg[BIT_MIDNIGHT] = 1'b1;
    end
    if (ivl_match) begin
      next_cfg[BIT_ALARM] = 1'b1;
    end
  end

  // rst_n is the power-on reset; other resets never reach this block
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg <= CONFIG_RESET;
      key <= ZERO8;
      target <= ZERO8;
      pin_irq_config <= ZERO8;
      wake_pending <= 1'b0;
    end else if (clk_en) begin
      cfg <= next_cfg;
      if (wr_key) begin
        key <= sfr_wdata;
      end
      if (wr_target) begin
        target <= sfr_wdata;
      end
      if (wr_pin) begin
        pin_irq_config <= sfr_wdata;
      end
      if (midnight_wake && next_cfg[BIT_MIDNIGHT]) begin
        wake_pending <= 1'b1;
      end else if (!next_cfg[BIT_MIDNIGHT]) begin
        wake_pending <= 1'b0;
      end
    end
  end

  assign deep_saving_block = wake_pending && cfg[BIT_MIDNIGHT];
  assign rtc_irq = cfg[BIT_MIDNIGHT] || cfg[BIT_ALARM];

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  assign sfr_hit = addr_is(sfr_addr, ADDR_CONFIG) || addr_is(sfr_addr, ADDR_FRACTION) ||
                   addr_is(sfr_addr, ADDR_SECOND) || addr_is(sfr_addr, ADDR_MINUTE) ||
                   addr_is(sfr_addr, ADDR_HOUR) || addr_is(sfr_addr, ADDR_TARGET) ||
                   addr_is(sfr_addr, ADDR_KEY) || addr_is(sfr_addr, ADDR_PIN_IRQ);
  assign next_rdata = addr_is(sfr_addr, ADDR_CONFIG) ? cfg :
                      addr_is(sfr_addr, ADDR_FRACTION) ? frac_c :
                      addr_is(sfr_addr, ADDR_SECOND) ? sec_c :
                      addr_is(sfr_addr, ADDR_MINUTE) ? min_c :
                      addr_is(sfr_addr, ADDR_HOUR) ? hour_c :
                      addr_is(sfr_addr, ADDR_TARGET) ? target :
                      addr_is(sfr_addr, ADDR_KEY) ? key :
                      addr_is(sfr_addr, ADDR_PIN_IRQ) ? pin_irq_config : ZERO8;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_rdata <= ZERO8;
    end else if (clk_en && sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule

/* File: rtccfg_properties.sv */
`timescale 1ns/1ps
module rtccfg_properties
  import rtccfg_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic midnight_wake,
  input wire logic deep_saving_block,
  input wire logic rtc_irq,
  input wire logic [7:0] pin_irq_config
);
  // ----
  // key shadow
  // ----
  logic [7:0] key_q;
  wire logic wr_en = sfr_wr && clk_en;
  wire logic rd_en = sfr_rd && clk_en;
  wire logic pin_open = wr_en && sfr_addr == ADDR_PIN_IRQ && key_q == UNLOCK_VALUE;
  wire logic cfg_wr = wr_en && sfr_addr == ADDR_CONFIG;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) key_q <= ZERO8;
    else if (wr_en && sfr_addr == ADDR_KEY) key_q <= sfr_wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence pin_open_s;
    pin_open;
  endsequence
  sequence key_read_s;
    rd_en && sfr_addr == ADDR_KEY;
  endsequence
  sequence block_held_s;
    deep_saving_block && !cfg_wr;
  endsequence
  hit_map_a: assert property (sfr_hit == ((sfr_addr >= ADDR_CONFIG &&
    sfr_addr <= ADDR_TARGET) || sfr_addr == ADDR_KEY || sfr_addr == ADDR_PIN_IRQ))
    else $error("hit flag wrong");
  unmap_read_a: assert property (rd_en && !sfr_hit |=> sfr_rdata == ZERO8)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_en |=> $stable(sfr_rdata))
    else $error("read data moved");
  key_read_a: assert property (key_read_s |=> sfr_rdata == $past(key_q))
    else $error("key readback wrong");
  pin_write_a: assert property (pin_open_s |=> pin_irq_config == $past(sfr_wdata))
    else $error("unlocked pin write lost");
  pin_guard_a: assert property (!pin_open |=> $stable(pin_irq_config))
    else $error("locked pin config changed");
  block_irq_a: assert property (deep_saving_block |-> rtc_irq)
    else $error("block without midnight flag");
  block_hold_a: assert property (block_held_s |=> deep_saving_block)
    else $error("deep saving block dropped early");
  irq_hold_a: assert property (rtc_irq && !cfg_wr |=> rtc_irq)
    else $error("flag dropped without clear");
  freeze_a: assert property (!clk_en |=> $stable(rtc_irq) && $stable(pin_irq_config))
    else $error("state moved while frozen");
  reset_out_a: assert property ($rose(rst_n) |-> sfr_rdata == ZERO8 &&
    pin_irq_config == ZERO8 && !rtc_irq && !deep_saving_block)
    else $error("reset outputs wrong");
endmodule
bind rtccfg_top rtccfg_properties #(.TICK_DIV(TICK_DIV)) chk (.*);

/* File: rtccfg_top_test.sv */
`timescale 1ns/1ps
module rtccfg_top_test
  import rtccfg_pkg::*;
;
  localparam int TD = 4;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d;} rtccfg_row_t;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic sfr_wr = 1'h0;
  logic sfr_rd = 1'h0;
  logic midnight_wake = 1'h0;
  logic [7:0] sfr_addr = 8'h00_00;
  logic [7:0] sfr_wdata = 8'h00_00;
  logic [7:0] sfr_rdata;
  logic [7:0] pin_irq_config;
  logic sfr_hit;
  logic deep_saving_block;
  logic rtc_irq;
  int error_cnt = 0;
  int checks = 0;
  rtccfg_row_t rows [14] = '{
    '{1'h0, ADDR_KEY, ZERO8},
    '{1'h1, ADDR_HOUR, 8'h00_05},
    '{1'h0, ADDR_HOUR, ZERO8},
    '{1'h1, ADDR_KEY, UNLOCK_VALUE},
    '{1'h1, ADDR_HOUR, 8'h00_17},
    '{1'h0, ADDR_HOUR, 8'h00_17},
    '{1'h1, ADDR_PIN_IRQ, 8'h00_80},
    '{1'h1, ADDR_KEY, ZERO8},
    '{1'h1, ADDR_PIN_IRQ, 8'h00_11},
    '{1'h0, ADDR_PIN_IRQ, 8'h00_80},
    '{1'h1, 8'h00_A7, 8'h00_33},
    '{1'h0, 8'h00_A7, ZERO8},
    '{1'h1, ADDR_CONFIG, 8'h00_85},
    '{1'h0, ADDR_CONFIG, CONFIG_RESET}
  };
  rtccfg_top #(.TICK_DIV(TD)) dut (.*);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= 1'h1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_rd <= 1'h1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd <= 1'h0;
    @(posedge ref_clk);
    #1;
    cmp(sfr_rdata, e);
  endtask
  task automatic wait_irq(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (rtc_irq === 1'h1) return;
    end
    cmp({7'h00, rtc_irq}, 8'h00_01);
    end_sim();
  endtask
  // fraction zeroed first so no carry slips in while loading
  task automatic set_time(input logic [7:0] h, m, s, f);
    wr(ADDR_FRACTION, ZERO8);
    wr(ADDR_HOUR, h);
    wr(ADDR_MINUTE, m);
    wr(ADDR_SECOND, s);
    wr(ADDR_FRACTION, f);
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(ADDR_CONFIG, CONFIG_RESET);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
      cmp({7'h00, sfr_hit}, {7'h00, rows[i].a != 8'h00_A7});
    end
    cmp(pin_irq_config, 8'h00_80);
    $display("register table done");
    wr(ADDR_KEY, UNLOCK_VALUE);
    wr(ADDR_CONFIG, 8'h00_41);
    set_time(HOUR_LAST_24, SIXTY_LAST, SIXTY_LAST, FRACTION_LAST);
    wait_irq(4 * TD);
    @(posedge ref_clk);
    midnight_wake <= 1'h1;
    rd(ADDR_HOUR, ZERO8);
    rd(ADDR_CONFIG, 8'h00_C1);
    cmp({7'h00, deep_saving_block}, 8'h00_01);
    wr(ADDR_CONFIG, 8'h00_41);
    #1;
    cmp({6'h00, deep_saving_block, rtc_irq}, ZERO8);
    @(posedge ref_clk);
    midnight_wake <= 1'h0;
    wr(ADDR_CONFIG, CONFIG_RESET);
    set_time(HOUR_LAST_24, SIXTY_LAST, SIXTY_LAST, FRACTION_LAST);
    clk_en <= 1'h0;
    repeat (5) @(posedge ref_clk);
    clk_en <= 1'h1;
    repeat (3 * TD) @(posedge ref_clk);
    rd(ADDR_HOUR, 8'h00_18);
    cmp({7'h00, rtc_irq}, ZERO8);
    $display("rollover test done");
    wr(ADDR_TARGET, 8'h00_01);
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_CONFIG, CONFIG_RESET);
      wr(ADDR_CONFIG, {2'h0, b[1:0], 4'h3});
      #1;
      cmp({7'h00, rtc_irq}, ZERO8);
      set_time(ZERO8, b > 2 ? SIXTY_LAST : ZERO8, b > 1 ? SIXTY_LAST : ZERO8,
        b > 0 ? FRACTION_LAST : ZERO8);
      wait_irq(4 * TD);
      rd(ADDR_CONFIG, {2'h0, b[1:0], 4'h7});
    end
    $display("time base test done");
    wr(ADDR_TARGET, 8'h00_03);
    wr(ADDR_CONFIG, 8'h00_03);
    wait_irq(8 * TD);
    wr(ADDR_CONFIG, 8'h00_03);
    wait_irq(8 * TD);
    wr(ADDR_CONFIG, CONFIG_RESET);
    wr(ADDR_CONFIG, 8'h00_0B);
    wait_irq(8 * TD);
    wr(ADDR_CONFIG, 8'h00_0B);
    repeat (16 * TD) @(posedge ref_clk);
    #1;
    cmp({7'h00, rtc_irq}, ZERO8);
    $display("interval mode test done");
    wr(ADDR_CONFIG, 8'h00_41);
    rst_n <= 1'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(ADDR_CONFIG, CONFIG_RESET);
    $display("reset test done");
    end_sim();
  end
endmodule
